/* File: hw/cmp_out_chan.sv */
// One compare output channel: output latch and its match/TOP actions
`timescale 1ns/10ps
module cmp_out_chan
  import timer16_pkg::*;
(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire action_type     action,
  input  wire mode_class_type cls,
  input  wire logic           toggle_ok,
  input  wire logic           match,
  input  wire logic           at_top,
  input  wire logic           cmp_is_top,
  input  wire logic           count_down,
  output logic                cmp_out,
  output logic                drive
);
  logic next_cmp_out;

  always_comb begin
    drive = (action != 2'b00) && ((action != 2'b01) || toggle_ok);
    next_cmp_out = cmp_out;
    unique case (cls)
      cls_normal, cls_ctc: begin
        if (match) begin
          unique case (action)
            2'b00: next_cmp_out = cmp_out;
            2'b01: next_cmp_out = ~cmp_out;
            2'b10: next_cmp_out = 1'b0;
            2'b11: next_cmp_out = 1'b1;
          endcase
        end
      end
      cls_fast: begin
        if (action == 2'b01 && toggle_ok && match) begin
          next_cmp_out = ~cmp_out;
        end
        if (action[1]) begin
          // Match at TOP is dropped so the pin does not glitch
          if (match && !cmp_is_top) begin
            next_cmp_out = action[0];
          end
          if (at_top) begin
            next_cmp_out = ~action[0];
          end
        end
      end
      cls_dual: begin
        if (action == 2'b01 && toggle_ok && match) begin
          next_cmp_out = ~cmp_out;
        end
        if (action[1] && match) begin
          next_cmp_out = count_down ? ~action[0] : action[0];
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_out <= 1'b0;
    end else begin
      cmp_out <= next_cmp_out;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_nonpwm_set: assert property (
    ((cls == cls_normal || cls == cls_ctc) && action == 2'b11 && match)
      |=> cmp_out) else $error("set on match failed");
  a_nonpwm_toggle: assert property (
    ((cls == cls_normal || cls == cls_ctc) && action == 2'b01 && match)
      |=> cmp_out != $past(cmp_out)) else $error("toggle failed");
  a_fast_top_set: assert property (
    (cls == cls_fast && action == 2'b10 && at_top) |=> cmp_out)
    else $error("fast pwm top set failed");
  a_fast_match_clr: assert property (
    (cls == cls_fast && action == 2'b10 && match && !cmp_is_top
     && !at_top) |=> !cmp_out) else $error("fast pwm clear failed");
  a_fast_top_only: assert property (
    (cls == cls_fast && action == 2'b11 && match && cmp_is_top)
      |=> !cmp_out) else $error("match at top not ignored");
  a_dual_up_clear: assert property (
    (cls == cls_dual && action == 2'b10 && match && !count_down)
      |=> !cmp_out) else $error("up-count clear failed");
  a_dual_down_set: assert property (
    (cls == cls_dual && action == 2'b10 && match && count_down)
      |=> cmp_out) else $error("down-count set failed");
  c_dual_toggle: cover property (
    cls == cls_dual && action == 2'b01 && toggle_ok && match);
endmodule

/* File: hw/timer16_compare_output_mode.sv */
// Timer with three compare outputs, waveform modes and APB registers
//
// Summary of operation
// - Nonzero action field of a channel hands its pin to the compare output, except code 1 where that channel may not toggle.
// - Non-PWM: code 0 off, 1 toggle, 2 clear, 3 set on match.
// - Fast PWM code 1 toggles channel A only in modes 14/15.
// - Fast PWM code 2 clears on match, sets at TOP; code 3 reversed.
// - Fast PWM, compare equal TOP, upper bit set: only the TOP action.
// - Dual-slope code 1 toggles channel A only in modes 8 to 11.
// - Dual-slope code 2 clears on up match, sets on down match.
// - Control bits 1:0 plus two bits of control B form the mode.
// - Modes give normal, clear-on-match, fast, phase and phase-freq PWM.
// - Modes 8 and 9 are dual-slope with TOP from capture or compare A.
// - Dual-slope counts zero up to TOP, then back down to zero.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`include "timer16_params.svh"
module timer16_compare_output_mode
  import timer16_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             cmp_out_a_pin,
  output logic             cmp_out_a_oe,
  output logic             cmp_out_b_pin,
  output logic             cmp_out_b_oe,
  output logic             cmp_out_c_pin,
  output logic             cmp_out_c_oe
);
  function automatic mode_class_type class_of(input logic [3:0] w);
    unique case (w)
      4'd0, 4'd13:                  class_of = cls_normal;
      4'd4, 4'd12:                  class_of = cls_ctc;
      4'd5, 4'd6, 4'd7, 4'd14, 4'd15: class_of = cls_fast;
      default:                      class_of = cls_dual;
    endcase
  endfunction

  function automatic logic [15:0] top_of(input logic [3:0] w,
                                         input logic [15:0] cap,
                                         input logic [15:0] cmpa);
    unique case (w)
      4'd1, 4'd5:                top_of = `TOP_8BIT;
      4'd2, 4'd6:                top_of = `TOP_9BIT;
      4'd3, 4'd7:                top_of = `TOP_10BIT;
      4'd8, 4'd10, 4'd12, 4'd14: top_of = cap;
      4'd4, 4'd9, 4'd11, 4'd15:  top_of = cmpa;
      default:                   top_of = `TOP_MAX;
    endcase
  endfunction

  logic [7:0]  timer16_ctrl_a;
  logic [7:0]  timer16_ctrl_b;
  logic [15:0] cmp_value_a;
  logic [15:0] cmp_value_b;
  logic [15:0] cmp_value_c;
  logic [15:0] top_capture;
  logic [15:0] count;
  logic        count_down;
  logic [7:0]  pin_ctrl;
  logic [7:0]  next_ctrl_a;
  logic [7:0]  next_ctrl_b;
  logic [15:0] next_cmp_a;
  logic [15:0] next_cmp_b;
  logic [15:0] next_cmp_c;
  logic [15:0] next_top_capture;
  logic [15:0] next_count;
  logic        next_count_down;
  logic [7:0]  next_pin_ctrl;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic [2:0]  next_pin;
  logic [2:0]  next_oe;
  logic        wr_en;
  logic        addr_ok;

  logic [3:0]     waveform_sel;
  mode_class_type cls;
  logic [15:0]    top_val;
  logic           at_top;
  logic           timer_run;
  logic [15:0]    cmp_val [3];
  action_type     act [3];
  logic [2:0]     match;
  logic [2:0]     toggle_ok;
  logic [2:0]     cmp_out;
  logic [2:0]     drive;

  assign waveform_sel = {timer16_ctrl_b[`WAVE_HIGH_MSB -: 2],
                         timer16_ctrl_a[`WAVE_LOW_MSB -: 2]};
  assign cls       = class_of(waveform_sel);
  assign top_val   = top_of(waveform_sel, top_capture, cmp_value_a);
  assign at_top    = (count == top_val);
  assign timer_run = (timer16_ctrl_b[`CLK_SEL_MSB -: 3] != 3'b000);
  assign cmp_val[0] = cmp_value_a;
  assign cmp_val[1] = cmp_value_b;
  assign cmp_val[2] = cmp_value_c;
  assign act[0] = timer16_ctrl_a[`ACT_A_MSB -: 2];
  assign act[1] = timer16_ctrl_a[`ACT_B_MSB -: 2];
  assign act[2] = timer16_ctrl_a[`ACT_C_MSB -: 2];

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_chan
      assign match[gi] = (count == cmp_val[gi]);
      if (gi == 0) begin : g_a
        assign toggle_ok[gi] =
          (cls == cls_normal || cls == cls_ctc) ||
          (cls == cls_fast && waveform_sel[3:1] == 3'b111) ||
          (waveform_sel[3:2] == 2'b10);
      end else begin : g_bc
        assign toggle_ok[gi] = (cls == cls_normal || cls == cls_ctc);
      end
      cmp_out_chan u_chan (
        .pclk       (pclk),
        .presetn    (presetn),
        .action     (act[gi]),
        .cls        (cls),
        .toggle_ok  (toggle_ok[gi]),
        .match      (match[gi]),
        .at_top     (at_top),
        .cmp_is_top (cmp_val[gi] == top_val),
        .count_down (count_down),
        .cmp_out    (cmp_out[gi]),
        .drive      (drive[gi])
      );
    end
  endgenerate

  // Counter sequencing; a software write to the count wins over counting
  always_comb begin
    next_count      = count;
    next_count_down = count_down;
    if (timer_run) begin
      unique case (cls)
        cls_normal: next_count = count + 16'h0001;
        cls_ctc, cls_fast: next_count = at_top ? 16'h0000
                                               : count + 16'h0001;
        cls_dual: begin
          if (at_top) begin
            next_count_down = 1'b1;
            next_count      = count - 16'h0001;
          end else if (count_down && count == 16'h0000) begin
            next_count_down = 1'b0;
            next_count      = 16'h0001;
          end else begin
            next_count = count_down ? count - 16'h0001 : count + 16'h0001;
          end
        end
      endcase
      if (cls != cls_dual) begin
        next_count_down = 1'b0;
      end
    end
    if (wr_en && paddr == `ADDR_COUNT) begin
      next_count = pwdata[15:0];
    end
  end

  // Pin takes compare output when the action field claims it
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      next_pin[i] = drive[i] ? cmp_out[i]
                             : pin_ctrl[`PIN_DATA_LSB + i];
      next_oe[i]  = pin_ctrl[`PIN_DIR_LSB + i];
    end
  end

  // APB slave: one wait-free access phase, pready raised from setup
  assign wr_en = psel && penable && pready && pwrite;
  always_comb begin
    addr_ok = (paddr[1:0] == 2'b00) && (paddr <= `ADDR_STATUS);
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      `ADDR_CTRL_A:      next_prdata[7:0]  = timer16_ctrl_a;
      `ADDR_CTRL_B:      next_prdata[7:0]  = timer16_ctrl_b;
      `ADDR_CMP_A:       next_prdata[15:0] = cmp_value_a;
      `ADDR_CMP_B:       next_prdata[15:0] = cmp_value_b;
      `ADDR_CMP_C:       next_prdata[15:0] = cmp_value_c;
      `ADDR_TOP_CAPTURE: next_prdata[15:0] = top_capture;
      `ADDR_COUNT:       next_prdata[15:0] = count;
      `ADDR_PIN_CTRL:    next_prdata[7:0]  = pin_ctrl;
      `ADDR_STATUS:      next_prdata[8:0]  = {count_down, 1'b0, drive,
                                              1'b0, cmp_out};
      default:           next_prdata = 32'h0000_0000;
    endcase
    next_pready  = psel && !penable;
    next_pslverr = psel && !penable && !addr_ok;
    next_ctrl_a      = timer16_ctrl_a;
    next_ctrl_b      = timer16_ctrl_b;
    next_cmp_a       = cmp_value_a;
    next_cmp_b       = cmp_value_b;
    next_cmp_c       = cmp_value_c;
    next_top_capture = top_capture;
    next_pin_ctrl    = pin_ctrl;
    if (wr_en) begin
      unique case (paddr)
        `ADDR_CTRL_A:      next_ctrl_a      = pwdata[7:0];
        // Bit 5 is reserved and always reads zero
        `ADDR_CTRL_B:      next_ctrl_b      = pwdata[7:0] & 8'hDF;
        `ADDR_CMP_A:       next_cmp_a       = pwdata[15:0];
        `ADDR_CMP_B:       next_cmp_b       = pwdata[15:0];
        `ADDR_CMP_C:       next_cmp_c       = pwdata[15:0];
        `ADDR_TOP_CAPTURE: next_top_capture = pwdata[15:0];
        `ADDR_PIN_CTRL:    next_pin_ctrl    = pwdata[7:0] & 8'h77;
        default:           next_ctrl_a      = timer16_ctrl_a;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer16_ctrl_a <= `CTRL_A_RESET;
      timer16_ctrl_b <= `CTRL_B_RESET;
      cmp_value_a    <= `CMP_RESET;
      cmp_value_b    <= `CMP_RESET;
      cmp_value_c    <= `CMP_RESET;
      top_capture    <= `CMP_RESET;
      count          <= `CMP_RESET;
      count_down     <= 1'b0;
      pin_ctrl       <= `PIN_CTRL_RESET;
      prdata         <= 32'h0000_0000;
      pready         <= 1'b0;
      pslverr        <= 1'b0;
      {cmp_out_c_pin, cmp_out_b_pin, cmp_out_a_pin} <= 3'b000;
      {cmp_out_c_oe, cmp_out_b_oe, cmp_out_a_oe}    <= 3'b000;
    end else begin
      timer16_ctrl_a <= next_ctrl_a;
      timer16_ctrl_b <= next_ctrl_b;
      cmp_value_a    <= next_cmp_a;
      cmp_value_b    <= next_cmp_b;
      cmp_value_c    <= next_cmp_c;
      top_capture    <= next_top_capture;
      count          <= next_count;
      count_down     <= next_count_down;
      pin_ctrl       <= next_pin_ctrl;
      prdata         <= next_prdata;
      pready         <= next_pready;
      pslverr        <= next_pslverr;
      {cmp_out_c_pin, cmp_out_b_pin, cmp_out_a_pin} <= next_pin;
      {cmp_out_c_oe, cmp_out_b_oe, cmp_out_a_oe}    <= next_oe;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pin_takeover: assert property (
    drive[0] |=> cmp_out_a_pin == $past(cmp_out[0]))
    else $error("pin A not taken by compare output");
  a_fast_b_off: assert property (
    (cls == cls_fast && act[1] == 2'b01) |-> !drive[1])
    else $error("channel B toggles in fast pwm");
  a_fast_a_off: assert property (
    (cls == cls_fast && act[0] == 2'b01 && waveform_sel[3:1] != 3'b111)
      |-> !drive[0]) else $error("channel A toggle in wrong mode");
  a_dual_a_mode: assert property (
    (cls == cls_dual && act[0] == 2'b01)
      |-> drive[0] == (waveform_sel[3:2] == 2'b10))
    else $error("dual toggle enable wrong");
  a_dual_turn: assert property (
    (cls == cls_dual && timer_run && at_top && top_val != 16'h0000
     && !wr_en) |=> count_down && count == $past(top_val) - 16'h0001)
    else $error("dual slope did not turn at top");
  a_dual_bottom: assert property (
    (cls == cls_dual && timer_run && count_down && count == 16'h0000
     && !at_top && !wr_en) |=> !count_down ##0 count == 16'h0001)
    else $error("dual slope did not turn at bottom");
  a_mode_sel: assert property (
    (waveform_sel == 4'd8) |-> cls == cls_dual && top_val == top_capture)
    else $error("mode 8 decode wrong");
  a_apb_ready: assert property (
    (psel && !penable) |=> pready ##1 !pready)
    else $error("apb ready timing wrong");
  c_fast_pwm: cover property (cls == cls_fast && at_top && drive[0]);
  c_dual_pwm: cover property (cls == cls_dual && count_down && match[1]);
  c_ctc_match: cover property (cls == cls_ctc && match[2] && drive[2]);
  c_bad_addr: cover property (pslverr && pready);
endmodule

/* File: hw/timer16_params.svh */
// Register offsets, field positions, reset values and fixed TOP values
`ifndef TIMER16_PARAMS_SVH
`define TIMER16_PARAMS_SVH
`define ADDR_CTRL_A      8'h00
`define ADDR_CTRL_B      8'h04
`define ADDR_CMP_A       8'h08
`define ADDR_CMP_B       8'h0C
`define ADDR_CMP_C       8'h10
`define ADDR_TOP_CAPTURE 8'h14
`define ADDR_COUNT       8'h18
`define ADDR_PIN_CTRL    8'h1C
`define ADDR_STATUS      8'h20
`define CTRL_A_RESET     8'h00
`define CTRL_B_RESET     8'h00
`define CMP_RESET        16'h0000
`define PIN_CTRL_RESET   8'h00
`define ACT_A_MSB        7
`define ACT_B_MSB        5
`define ACT_C_MSB        3
`define WAVE_LOW_MSB     1
`define WAVE_HIGH_MSB    4
`define CLK_SEL_MSB      2
`define PIN_DIR_LSB      0
`define PIN_DATA_LSB     4
`define TOP_MAX          16'hFFFF
`define TOP_8BIT         16'h00FF
`define TOP_9BIT         16'h01FF
`define TOP_10BIT        16'h03FF
`endif

/* File: hw/timer16_pkg.sv */
// Types shared by the compare output logic
package timer16_pkg;
  typedef enum logic [3:0] {
    cls_normal = 4'b0001,
    cls_ctc    = 4'b0010,
    cls_fast   = 4'b0100,
    cls_dual   = 4'b1000
  } mode_class_type;
  typedef logic [1:0] action_type;
endpackage

/* File: tb/timer16_compare_output_mode_tb.sv */
// Self-checking bench for the timer compare output block
`timescale 1ns/10ps
`include "timer16_params.svh"
module timer16_compare_output_mode_tb;
  typedef struct {
    logic [3:0]  mode;
    int          ch;
    logic [1:0]  act;
    logic [15:0] cmp;
    logic [15:0] top;
    logic [2:0]  pdata;
    int          high;
  } row_type;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  wire  [2:0]  pins;
  wire  [2:0]  oe;
  logic [31:0] rdat;
  logic        rerr;
  int          fail_count = 0;
  int          total_checks = 0;

  // Outside modes 0, 3 and 5, short TOP values keep every period within the 40-cycle window; rows in those modes hold the pin steady
  row_type rows[20] = '{
    '{4'h4, 1, 2'h1, 16'h0003, 16'h0009, 3'h0, 20},
    '{4'hC, 0, 2'h1, 16'h0003, 16'h0009, 3'h0, 20},
    '{4'h4, 2, 2'h2, 16'h0003, 16'h0009, 3'h7, 0},
    '{4'h4, 0, 2'h3, 16'h0009, 16'h0009, 3'h0, 40},
    '{4'h0, 2, 2'h3, 16'h0002, 16'h0009, 3'h0, 40},
    '{4'h0, 1, 2'h0, 16'h0003, 16'h0009, 3'h2, 40},
    '{4'hE, 1, 2'h2, 16'h0003, 16'h0009, 3'h0, 16},
    '{4'hE, 2, 2'h3, 16'h0003, 16'h0009, 3'h0, 24},
    '{4'hF, 0, 2'h1, 16'h0009, 16'h0009, 3'h0, 20},
    '{4'hE, 1, 2'h1, 16'h0003, 16'h0009, 3'h2, 40},
    '{4'h5, 0, 2'h1, 16'h0003, 16'h0009, 3'h1, 40},
    '{4'hE, 1, 2'h2, 16'h0009, 16'h0009, 3'h0, 40},
    '{4'hE, 2, 2'h3, 16'h0009, 16'h0009, 3'h4, 0},
    '{4'h8, 1, 2'h2, 16'h0004, 16'h000A, 3'h0, 16},
    '{4'h8, 2, 2'h3, 16'h0004, 16'h000A, 3'h0, 24},
    '{4'h9, 0, 2'h1, 16'h000A, 16'h000A, 3'h0, 20},
    '{4'hB, 0, 2'h1, 16'h000A, 16'h000A, 3'h0, 20},
    '{4'hA, 1, 2'h1, 16'h0004, 16'h000A, 3'h2, 40},
    '{4'hA, 2, 2'h2, 16'h0004, 16'h000A, 3'h0, 16},
    '{4'h3, 0, 2'h1, 16'h0004, 16'h000A, 3'h1, 40}
  };

  timer16_compare_output_mode dut_u (
    .pclk          (pclk),
    .presetn       (presetn),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .cmp_out_a_pin (pins[0]),
    .cmp_out_a_oe  (oe[0]),
    .cmp_out_b_pin (pins[1]),
    .cmp_out_b_oe  (oe[1]),
    .cmp_out_c_pin (pins[2]),
    .cmp_out_c_oe  (oe[2])
  );

  always #10 pclk = ~pclk;

  task complete_run;
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Entered just after a rising edge; one idle cycle follows each transfer
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      fail_count++;
      complete_run();
    end
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // Counts pin-high cycles over whole periods, so the result does not
  // depend on where in the period the window starts
  task automatic run_row(input row_type r);
    logic [31:0] d;
    logic [15:0] ca;
    int          hi;
    ca = (r.mode inside {4'h4, 4'h9, 4'hB, 4'hF}) ? r.top : r.cmp;
    wr(`ADDR_CTRL_B, {27'h0, r.mode[3:2], 3'h0});
    d = 32'(r.act) << (6 - 2 * r.ch);
    d[1:0] = r.mode[1:0];
    wr(`ADDR_CTRL_A, d);
    wr(`ADDR_CMP_A, {16'h0, ca});
    wr(`ADDR_CMP_B, {16'h0, r.cmp});
    wr(`ADDR_CMP_C, {16'h0, r.cmp});
    wr(`ADDR_TOP_CAPTURE, {16'h0, r.top});
    wr(`ADDR_PIN_CTRL, {25'h0, r.pdata, 4'h7});
    wr(`ADDR_COUNT, 32'h0);
    wr(`ADDR_CTRL_B, {27'h0, r.mode[3:2], 3'h1});
    repeat (45) @(posedge pclk);
    hi = 0;
    repeat (40) begin
      @(posedge pclk);
      if (pins[r.ch] === 1'b1) begin
        hi++;
      end
    end
    chk("high_cycles", r.high, hi);
    chk("oe", 32'h7, {29'h0, oe});
  endtask

  initial begin
    pclk    = 1'b0;
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("pins", 32'h0, {29'h0, pins});
    chk("oe", 32'h0, {29'h0, oe});
    rd(`ADDR_CTRL_A);
    chk("ctrl_a", 32'h0, rdat);
    rd(`ADDR_CTRL_B);
    chk("ctrl_b", 32'h0, rdat);
    rd(`ADDR_PIN_CTRL);
    chk("pin_ctrl", 32'h0, rdat);
    wr(`ADDR_CTRL_A, 32'hFD);
    rd(`ADDR_CTRL_A);
    chk("ctrl_a", 32'hFD, rdat);
    // Reserved bit 5 must read back as zero
    wr(`ADDR_CTRL_B, 32'h38);
    rd(`ADDR_CTRL_B);
    chk("ctrl_b", 32'h18, rdat);
    wr(8'h24, 32'hFF);
    chk("pslverr", 32'h1, {31'h0, rerr});
    rd(8'h24);
    chk("pslverr", 32'h1, {31'h0, rerr});
    chk("prdata", 32'h0, rdat);
    rd(8'h02);
    chk("pslverr", 32'h1, {31'h0, rerr});
    foreach (rows[i]) begin
      run_row(rows[i]);
    end
    wr(`ADDR_PIN_CTRL, 32'h0);
    repeat (2) @(posedge pclk);
    chk("oe", 32'h0, {29'h0, oe});
    // Channel A is disconnected in mode 3, so all pins show port data
    wr(`ADDR_PIN_CTRL, 32'h77);
    repeat (2) @(posedge pclk);
    chk("pins", 32'h7, {29'h0, pins});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("pins", 32'h0, {29'h0, pins});
    chk("oe", 32'h0, {29'h0, oe});
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`ADDR_CTRL_A);
    chk("ctrl_a", 32'h0, rdat);
    complete_run();
  end
endmodule
